// >>> hdl/dsp_pins.sv
// pin-level data, strobe, mask and termination logic of the memory device
`timescale 1ns/100ps
// Overview of operation
// - low reset pin holds device reset, independent of the command clock (synchronised to the system clock)
// - leveling feedback on bit 0 / bit 8
// - read strobe edge-aligned; write strobe centred
// - strobes always differential true/complement pairs
// - mode bit 11 set: strobe termination on termination strobe
// - mode bit 11 clear: pin is write mask
// - termination strobe only on byte-wide parts
// - input-only pins get no termination
// - termination strobe follows termination control input
// - masked write beats are dropped
module dsp_pins import dsp_pkg::*; (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic device_reset_b,
	input wire dsp_ca_t ca,
	input wire logic ck,
	input wire logic [DQ_W-1:0] dq_i,
	output logic [DQ_W-1:0] dq_o,
	output logic dq_oe_b,
	input wire logic dqs_i,
	input wire logic dqs_b_i,
	output logic dqs_o,
	output logic dqs_b_o,
	output logic dqs_oe_b,
	input wire logic write_byte_mask,
	output logic term_dq,
	output logic term_dqs,
	output logic term_termination_strobe,
	output logic cmd_valid,
	output dsp_cmd_t cmd,
	output logic wr_valid,
	output logic [DQ_W-1:0] wr_data,
	input wire logic wr_ready,
	output logic wr_overflow,
	input wire logic [DQ_W-1:0] rd_data,
	output logic rd_take
);
	// two-flop synchronisers; the first stage feeds only the second
	dsp_ca_t ca_s1, ca_s2;
	logic [DQ_W-1:0] dq_s1, dq_s2;
	logic rst_s1, rst_s2;
	logic ck_s1, ck_s2, ck_s3;
	logic dqs_s1, dqs_s2, dqs_s3, dqsb_s1, dqsb_s2;
	logic mask_s1, mask_s2;
	// combined reset: board reset or device reset pin
	logic live;
	// edge events derived from synchronised levels
	logic ck_rise, ck_edge, dqs_edge, dqs_rise;
	// mode state
	logic [14:0] mode_register_one_reg;
	logic mpr_reg;
	logic cke_seen_reg, cke_prev_reg, self_refresh_reg;
	logic tstrobe_en, level_en;
	// burst engine
	dsp_state_t state_reg;
	logic [3:0] beat_reg;
	// write path buffer: output stage and one skid entry
	logic skid_v_reg;
	logic [DQ_W-1:0] skid_reg;
	logic push, buf_space;
	dsp_cmd_code_t code_now;

	// decode the command pins at a clock rising edge
	function automatic dsp_cmd_code_t decode(dsp_ca_t c, logic cke_prev, logic sr, logic multipurpose_register);
		logic [3:0] pins;
		pins = {c.cs_b, c.ras_b, c.cas_b, c.we_b};
		decode = CMD_NONE;
		if (cke_prev && !c.cke) begin
			// falling enable: refresh enters self refresh, else power-down
			decode = (pins == PIN_REFRESH) ? CMD_SELF_REFRESH_ENTRY : CMD_POWERDOWN_ENTRY;
		end else if (!cke_prev && c.cke) begin
			decode = sr ? CMD_SELF_REFRESH_EXIT : CMD_POWERDOWN_EXIT;
		end else if (!c.cke || c.cs_b) begin
			decode = CMD_NONE;
		end else if (pins == PIN_OPEN) begin
			decode = CMD_ROW_OPEN;
		end else if (pins == PIN_CLOSE) begin
			decode = c.addr[AP_BIT] ? CMD_ALL_BANK_CLOSE : CMD_BANK_CLOSE;
		end else if (pins == PIN_MODE) begin
			decode = CMD_MODE_SET;
		end else if (pins == PIN_REFRESH) begin
			decode = CMD_REFRESH;
		end else if (pins == PIN_ZQ) begin
			decode = c.addr[AP_BIT] ? CMD_LONG_CAL : CMD_SHORT_CAL;
		end else if (pins == PIN_READ) begin
			decode = multipurpose_register ? CMD_MULTIPURPOSE_READ : CMD_READ;
		end else if (pins == PIN_WRITE) begin
			decode = CMD_WRITE;
		end
	endfunction

	// synchronise every pin into the system clock
	always_ff @(posedge clock) begin
		ca_s1 <= ca;
		ca_s2 <= ca_s1;
		dq_s1 <= dq_i;
		dq_s2 <= dq_s1;
		ck_s1 <= ck;
		ck_s2 <= ck_s1;
		ck_s3 <= ck_s2;
		dqs_s1 <= dqs_i;
		dqs_s2 <= dqs_s1;
		dqs_s3 <= dqs_s2;
		dqsb_s1 <= dqs_b_i;
		dqsb_s2 <= dqsb_s1;
		mask_s1 <= write_byte_mask;
		mask_s2 <= mask_s1;
		rst_s1 <= device_reset_b;
		rst_s2 <= rst_s1;
	end

	// reset pin acts without command clock edges, after its two-flop system clock synchroniser
	assign live = rst_b && rst_s2;
	assign ck_edge = ck_s2 != ck_s3;
	assign ck_rise = ck_s2 && !ck_s3;
	// strobe edge counts only on a true differential pair
	assign dqs_edge = (dqs_s2 != dqs_s3) && (dqs_s2 != dqsb_s2);
	assign dqs_rise = dqs_edge && dqs_s2;
	// termination strobe exists on byte-wide parts only
	// wide parts treat the mode bit as zero
	assign tstrobe_en = mode_register_one_reg[MR1_TSTROBE_BIT] && (LANES == 1);
	assign level_en = mode_register_one_reg[MR1_LEVEL_BIT];
	assign code_now = decode(ca_s2, cke_prev_reg, self_refresh_reg, mpr_reg);

	// command reporting, mode registers and power state
	always_ff @(posedge clock) begin
		if (!live) begin
			cmd_valid <= 1'b0;
			cmd <= '0;
			mode_register_one_reg <= MR_RESET;
			mpr_reg <= 1'b0;
			cke_seen_reg <= 1'b0;
			cke_prev_reg <= 1'b0;
			self_refresh_reg <= 1'b0;
		end else begin
			cmd_valid <= 1'b0;
			if (ck_rise) begin
				cke_prev_reg <= ca_s2.cke;
				// termination stays off until enable first seen high
				if (ca_s2.cke) begin
					cke_seen_reg <= 1'b1;
				end
				if (code_now != CMD_NONE) begin
					cmd_valid <= 1'b1;
					cmd <= '{code: code_now, bank: ca_s2.bank, addr: ca_s2.addr};
				end
				if (code_now == CMD_SELF_REFRESH_ENTRY) begin
					self_refresh_reg <= 1'b1;
				end else if (code_now == CMD_SELF_REFRESH_EXIT) begin
					self_refresh_reg <= 1'b0;
				end
				// mode set to register one or three updates local copies
				if (code_now == CMD_MODE_SET && ca_s2.bank == BA_MR1) begin
					mode_register_one_reg <= ca_s2.addr;
				end else if (code_now == CMD_MODE_SET && ca_s2.bank == BA_MR3) begin
					mpr_reg <= ca_s2.addr[MR3_MPR_BIT];
				end
			end
		end
	end

	// only data-side pins carry termination flags
	// termination control gates every terminated pair
	always_ff @(posedge clock) begin
		if (!live) begin
			term_dq <= 1'b0;
			term_dqs <= 1'b0;
			term_termination_strobe <= 1'b0;
		end else begin
			// no termination while the burst engine is in the read state
			term_dq <= ca_s2.termination_control && cke_seen_reg && state_reg != ST_READ;
			term_dqs <= ca_s2.termination_control && cke_seen_reg && state_reg != ST_READ;
			// same termination as the strobe pair, further gated by the termination strobe enable
			term_termination_strobe <= ca_s2.termination_control && cke_seen_reg
				&& state_reg != ST_READ && tstrobe_en;
		end
	end

	// burst engine: write capture, read drive and leveling feedback
	always_ff @(posedge clock) begin
		if (!live) begin
			state_reg <= ST_IDLE;
			beat_reg <= '0;
			dq_o <= '0;
			dq_oe_b <= 1'b1;
			dqs_o <= 1'b0;
			dqs_b_o <= 1'b1;
			dqs_oe_b <= 1'b1;
			rd_take <= 1'b0;
		end else begin
			rd_take <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					beat_reg <= '0;
					if (ck_rise && (code_now == CMD_READ || code_now == CMD_MULTIPURPOSE_READ)) begin
						state_reg <= ST_READ;
						dq_oe_b <= 1'b0;
						dqs_oe_b <= 1'b0;
						dqs_o <= 1'b0;
						dqs_b_o <= 1'b1;
					end else if (ck_rise && code_now == CMD_WRITE) begin
						state_reg <= ST_WRITE;
						dq_oe_b <= 1'b1;
					end else if (level_en && dqs_rise) begin
						// sample clock onto each lane's prime bit
						for (int i = 0; i < LANES; i++) begin
							dq_o[i*BYTE_W] <= ck_s2;
						end
						dq_oe_b <= 1'b0;
					end else if (!level_en && dqs_oe_b) begin
						// last read beat keeps the data pins until the strobe lets go
						dq_oe_b <= 1'b1;
					end
				end
				ST_WRITE: begin
					// host strobe centred, capture on each edge
					if (dqs_edge) begin
						beat_reg <= beat_reg + 4'h1;
						if (beat_reg == BEAT_LAST) begin
							state_reg <= ST_IDLE;
						end
					end
				end
				ST_READ: begin
					// complement always opposite the true strobe
					if (ck_edge) begin
						dq_o <= rd_data;
						rd_take <= 1'b1;
						dqs_o <= !dqs_o;
						dqs_b_o <= dqs_o;
						beat_reg <= beat_reg + 4'h1;
						if (beat_reg == BEAT_LAST) begin
							state_reg <= ST_IDLE;
						end
					end else if (beat_reg == BEAT_LAST + 4'h1) begin
						dq_oe_b <= 1'b1;
						dqs_oe_b <= 1'b1;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
			// release pins after the last read beat has stood
			if (state_reg == ST_IDLE && !level_en && !dqs_oe_b && ck_edge) begin
				dqs_oe_b <= 1'b1;
				dq_oe_b <= 1'b1;
			end
		end
	end

	// mask pin only when termination strobe off
	assign push = state_reg == ST_WRITE && dqs_edge && !(mask_s2 && !tstrobe_en);
	// room exists unless both entries hold words
	assign buf_space = !skid_v_reg;

	// two-entry write buffer; a receiver stall fills the skid entry
	always_ff @(posedge clock) begin
		if (!live) begin
			wr_valid <= 1'b0;
			wr_data <= '0;
			skid_v_reg <= 1'b0;
			skid_reg <= '0;
			wr_overflow <= 1'b0;
		end else if (wr_valid && wr_ready) begin
			if (skid_v_reg) begin
				wr_data <= skid_reg;
				skid_v_reg <= push;
				skid_reg <= dq_s2;
			end else begin
				wr_valid <= push;
				wr_data <= dq_s2;
			end
		end else if (push) begin
			if (!wr_valid) begin
				wr_valid <= 1'b1;
				wr_data <= dq_s2;
			end else if (buf_space) begin
				skid_v_reg <= 1'b1;
				skid_reg <= dq_s2;
			end else begin
				// pins cannot be stalled; a lost word is flagged sticky
				wr_overflow <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	property p_reset_quiet;
		!rst_s2 |=> dq_oe_b && dqs_oe_b && !term_dq && !cmd_valid;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("reset pin not obeyed");
	property p_level_fb;
		rst_s2 && state_reg == ST_IDLE && level_en && dqs_rise |=> dq_o[0] == $past(ck_s2) && !dq_oe_b;
	endproperty
	a_level_fb: assert property (p_level_fb) else $error("leveling feedback wrong");
	property p_read_edge;
		rst_s2 && state_reg == ST_READ && ck_edge |=> dqs_o != $past(dqs_o) && dq_o == $past(rd_data);
	endproperty
	a_read_edge: assert property (p_read_edge) else $error("read strobe not edge aligned");
	property p_diff;
		!dqs_oe_b |-> dqs_b_o == !dqs_o;
	endproperty
	a_diff: assert property (p_diff) else $error("strobe pair not complementary");
	// outside leveling, data and strobe are driven and released together
	property p_oe_pair;
		!level_en && !$past(level_en) |-> dq_oe_b == dqs_oe_b;
	endproperty
	a_oe_pair: assert property (p_oe_pair) else $error("data and strobe drive differ");
	property p_tstrobe;
		term_dq && $past(tstrobe_en) && $past(live) |-> term_termination_strobe;
	endproperty
	a_tstrobe: assert property (p_tstrobe) else $error("termination strobe not terminated");
	property p_mask;
		state_reg == ST_WRITE && dqs_edge && mask_s2 && !tstrobe_en |-> !push;
	endproperty
	a_mask: assert property (p_mask) else $error("masked beat accepted");
	property p_x8_only;
		term_termination_strobe |-> LANES == 1;
	endproperty
	a_x8_only: assert property (p_x8_only) else $error("termination strobe on wide part");
	property p_odt;
		live && !ca_s2.termination_control |=> !term_dq && !term_dqs && !term_termination_strobe;
	endproperty
	a_odt: assert property (p_odt) else $error("termination without control input");
	property p_cmd;
		live && ck_rise && code_now == CMD_REFRESH |=> cmd_valid && cmd.code == CMD_REFRESH;
	endproperty
	a_cmd: assert property (p_cmd) else $error("refresh not reported");

	c_write: cover property (state_reg == ST_WRITE && beat_reg == BEAT_LAST && dqs_edge);
	c_read: cover property (state_reg == ST_READ && beat_reg == BEAT_LAST && ck_edge);
	c_level: cover property (level_en && dqs_rise);
endmodule

// >>> pkg/dsp_pkg.sv
// shared types and constants for the data strobe pin block
package dsp_pkg;
	// fixed part width: one byte lane (byte-wide part)
	localparam int BYTE_W = 8;
	localparam int LANES = 1;
	localparam int DQ_W = BYTE_W * LANES;
	// burst framing in strobe or clock edges
	localparam logic [3:0] BEAT_LAST = 4'h7;
	// mode register selection by bank address
	localparam logic [2:0] BA_MR1 = 3'h1;
	localparam logic [2:0] BA_MR3 = 3'h3;
	// mode register one fields
	localparam int MR1_LEVEL_BIT = 7;
	localparam int MR1_TSTROBE_BIT = 11;
	// mode register three multipurpose register enable
	localparam int MR3_MPR_BIT = 2;
	// address bit that picks all banks or the long calibration
	localparam int AP_BIT = 10;
	localparam logic [14:0] MR_RESET = 15'h0000;
	// command pin codes {cs_b, ras_b, cas_b, we_b}
	localparam logic [3:0] PIN_MODE = 4'h0;
	localparam logic [3:0] PIN_REFRESH = 4'h1;
	localparam logic [3:0] PIN_CLOSE = 4'h2;
	localparam logic [3:0] PIN_OPEN = 4'h3;
	localparam logic [3:0] PIN_WRITE = 4'h4;
	localparam logic [3:0] PIN_READ = 4'h5;
	localparam logic [3:0] PIN_ZQ = 4'h6;
	// decoded commands handed to the core
	typedef enum logic [3:0] {
		CMD_NONE, CMD_ROW_OPEN, CMD_BANK_CLOSE, CMD_ALL_BANK_CLOSE, CMD_MODE_SET,
		CMD_REFRESH, CMD_LONG_CAL, CMD_SHORT_CAL, CMD_POWERDOWN_ENTRY,
		CMD_POWERDOWN_EXIT, CMD_SELF_REFRESH_ENTRY, CMD_SELF_REFRESH_EXIT,
		CMD_READ, CMD_WRITE, CMD_MULTIPURPOSE_READ
	} dsp_cmd_code_t;
	// command and address pins, sampled as one group
	typedef struct packed {
		logic cs_b;
		logic ras_b;
		logic cas_b;
		logic we_b;
		logic cke;
		logic termination_control;
		logic [2:0] bank;
		logic [14:0] addr;
	} dsp_ca_t;
	// decoded command with its address
	typedef struct packed {
		dsp_cmd_code_t code;
		logic [2:0] bank;
		logic [14:0] addr;
	} dsp_cmd_t;
	// burst engine states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WRITE = 3'b010,
		ST_READ = 3'b100
	} dsp_state_t;
endpackage

// >>> sim/dsp_ctl_model.sv
// controller-side model: command clock, command pins, write strobes and data
`timescale 1ns/100ps
module dsp_ctl_model import dsp_pkg::*; (
	input wire logic clock,
	output logic ck,
	output logic device_reset_b,
	output dsp_ca_t ca,
	output logic [DQ_W-1:0] dq,
	output logic dqs,
	output logic dqs_b,
	output logic write_byte_mask
);
	logic drv; // high while write data is on the wire
	initial begin
		ck = 1'b0;
		// reset pin high in normal running
		device_reset_b = 1'b1;
		ca = {4'hf, 20'h00000};
		dq = 8'h00;
		dqs = 1'b0;
		dqs_b = 1'b1;
		write_byte_mask = 1'b0;
		drv = 1'b0;
	end
	// command clock runs free, eight system clocks per period, each edge 10 ns before a system clock rising edge
	always #80 ck = ~ck;
	// released data wire keeps moving so a stale word never passes
	always @(posedge clock) begin
		if (!drv) begin
			dq <= ~dq;
		end
	end
	task automatic tick;
		@(posedge clock);
		#1;
	endtask
	// pins set up one system clock after the falling edge, 69 ns before the rising edge
	task automatic cmd(input dsp_ca_t v);
		@(negedge ck);
		tick;
		ca = v;
	endtask
	// strobe edge centred in each data beat
	// true and complement strobe move as one pair
	// mask travels with its own beat
	task automatic burst(input logic [7:0] base, input logic [7:0] mk);
		drv = 1'b1;
		for (int i = 0; i < 8; i++) begin
			tick;
			dq = base + 8'(i);
			write_byte_mask = mk[i];
			repeat (2) tick;
			dqs = ~dqs;
			dqs_b = ~dqs_b;
			repeat (2) tick;
		end
		write_byte_mask = 1'b0;
		drv = 1'b0;
	endtask
	// leveling pulse while the command clock sits at the given level
	task automatic lvl(input logic hi);
		do @(ck); while (ck !== hi);
		repeat (2) tick;
		dqs = 1'b1;
		dqs_b = 1'b0;
		repeat (10) tick;
		dqs = 1'b0;
		dqs_b = 1'b1;
	endtask
	task automatic rst(input logic v);
		tick;
		device_reset_b = v;
	endtask
endmodule

// >>> sim/dsp_pins_tb.sv
// self-checking bench for the data strobe pin block
`timescale 1ns/100ps
module dsp_pins_tb import dsp_pkg::*; ();
	typedef struct packed {
		dsp_ca_t ca;
		dsp_cmd_code_t code;
	} dsp_row_t;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic wr_ready = 1'b1;
	logic rd_chk = 1'b0; // read beats are judged only in the plain read
	logic [7:0] rd_cnt = 8'h00;
	logic ck, device_reset_b, mask, m_dqs, m_dqs_b, dqs_o, dqs_b_o, dqs_oe_b, dq_oe_b;
	logic term_dq, term_dqs, term_ts, cmd_valid, wr_valid, wr_overflow, rd_take;
	logic [DQ_W-1:0] m_dq, dq_o, wr_data;
	dsp_ca_t ca;
	dsp_cmd_t cmd;
	logic [7:0] got[$]; // accepted write words
	int mismatches = 0;
	int checks = 0;
	int cyc = 0;
	dsp_row_t rows[14];
	always #10 clock = ~clock;
	dsp_ctl_model u_ctl (.clock(clock), .ck(ck), .device_reset_b(device_reset_b), .ca(ca),
		.dq(m_dq), .dqs(m_dqs), .dqs_b(m_dqs_b), .write_byte_mask(mask));
	// wire levels: whoever has its enable low owns the pin
	dsp_pins u_dut (.clock(clock), .rst_b(rst_b), .device_reset_b(device_reset_b), .ca(ca),
		.ck(ck), .dq_i(dq_oe_b ? m_dq : dq_o), .dq_o(dq_o), .dq_oe_b(dq_oe_b),
		.dqs_i(dqs_oe_b ? m_dqs : dqs_o), .dqs_b_i(dqs_oe_b ? m_dqs_b : dqs_b_o),
		.dqs_o(dqs_o), .dqs_b_o(dqs_b_o), .dqs_oe_b(dqs_oe_b), .write_byte_mask(mask),
		.term_dq(term_dq), .term_dqs(term_dqs), .term_termination_strobe(term_ts),
		.cmd_valid(cmd_valid), .cmd(cmd), .wr_valid(wr_valid), .wr_data(wr_data),
		.wr_ready(wr_ready), .wr_overflow(wr_overflow), .rd_data(8'h40 + rd_cnt),
		.rd_take(rd_take));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// collect write words, judge read beats, cut a hang short
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
			got.push_back(wr_data);
		end
		if (rd_take === 1'b1 && rd_chk) begin
			check(dq_o, 8'h40 + rd_cnt);
			check(dqs_o, !rd_cnt[0]);
			check({dq_oe_b, dqs_oe_b, dqs_b_o}, {2'b00, rd_cnt[0]});
			rd_cnt <= rd_cnt + 8'h01;
		end
		if (cyc == 40000) begin
			mismatches++;
			test_done;
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	function automatic dsp_ca_t mk(logic [3:0] p, int e, int t, logic [2:0] b, logic [14:0] a);
		return {p, 1'(e), 1'(t), b, a};
	endfunction
	// one command, its report, then deselect keeping cke and termination
	task automatic issue(input dsp_ca_t v, input dsp_cmd_code_t code);
		int n;
		n = 0;
		u_ctl.cmd(v);
		while (cmd_valid !== 1'b1 && n < 16) begin
			tick(1);
			n++;
		end
		check({cmd_valid, cmd}, {1'b1, code, v.bank, v.addr});
		v.cs_b = 1'b1;
		u_ctl.cmd(v);
	endtask
	initial begin
		rows[0] = {mk(PIN_OPEN, 1, 0, 3'h2, 15'h0123), CMD_ROW_OPEN};
		rows[1] = {mk(PIN_CLOSE, 1, 0, 3'h2, 15'h0000), CMD_BANK_CLOSE};
		rows[2] = {mk(PIN_CLOSE, 1, 0, 3'h0, 15'h0400), CMD_ALL_BANK_CLOSE};
		rows[3] = {mk(PIN_REFRESH, 1, 0, 3'h0, 15'h0000), CMD_REFRESH};
		rows[4] = {mk(PIN_ZQ, 1, 0, 3'h0, 15'h0400), CMD_LONG_CAL};
		rows[5] = {mk(PIN_ZQ, 1, 0, 3'h0, 15'h0000), CMD_SHORT_CAL};
		rows[6] = {mk(PIN_MODE, 1, 0, 3'h2, 15'h0000), CMD_MODE_SET};
		rows[7] = {mk(PIN_REFRESH, 0, 0, 3'h0, 15'h0000), CMD_SELF_REFRESH_ENTRY};
		rows[8] = {mk(4'h7, 1, 0, 3'h0, 15'h0000), CMD_SELF_REFRESH_EXIT};
		rows[9] = {mk(4'h7, 0, 0, 3'h0, 15'h0000), CMD_POWERDOWN_ENTRY};
		rows[10] = {mk(4'h7, 1, 0, 3'h0, 15'h0000), CMD_POWERDOWN_EXIT};
		rows[11] = {mk(PIN_MODE, 1, 0, BA_MR3, 15'h0004), CMD_MODE_SET};
		rows[12] = {mk(PIN_READ, 1, 0, 3'h0, 15'h0000), CMD_MULTIPURPOSE_READ};
		rows[13] = {mk(PIN_MODE, 1, 0, BA_MR3, 15'h0000), CMD_MODE_SET};
		tick(5);
		check({dq_oe_b, dqs_oe_b, dqs_o, dqs_b_o, cmd_valid, wr_valid}, 6'h34);
		check({term_dq, term_dqs, term_ts}, 3'h0);
		tick(1);
		rst_b = 1'b1;
		tick(3);
		u_ctl.cmd(mk(4'hf, 1, 0, 3'h0, 15'h0000));
		tick(20);
		for (int i = 0; i < 14; i++) begin
			issue(rows[i].ca, rows[i].code);
		end
		// strobe termination on, then off, with termination control high
		issue(mk(PIN_MODE, 1, 1, BA_MR1, 15'h0800), CMD_MODE_SET);
		tick(12);
		check({term_dq, term_dqs, term_ts}, 3'h7);
		issue(mk(PIN_MODE, 1, 1, BA_MR1, 15'h0000), CMD_MODE_SET);
		tick(12);
		check({term_dq, term_dqs, term_ts}, 3'h6);
		// masked third beat must vanish, the rest keep strobe order
		got.delete();
		issue(mk(PIN_WRITE, 1, 0, 3'h0, 15'h0000), CMD_WRITE);
		u_ctl.burst(8'h10, 8'h04);
		tick(10);
		check({term_dq, term_dqs, term_ts}, 3'h0);
		check(got.size(), 7);
		for (int i = 0; i < 7; i++) begin
			check(got[i], 8'h10 + (i < 2 ? i : i + 1));
		end
		// strobe bit set: the shared pin stops masking, all eight beats land
		// byte-wide part, so the strobe bit may be set
		issue(mk(PIN_MODE, 1, 0, BA_MR1, 15'h0800), CMD_MODE_SET);
		got.delete();
		issue(mk(PIN_WRITE, 1, 0, 3'h0, 15'h0000), CMD_WRITE);
		u_ctl.burst(8'h30, 8'h04);
		tick(10);
		check(got.size(), 8);
		check(got[2], 8'h32);
		issue(mk(PIN_MODE, 1, 0, BA_MR1, 15'h0000), CMD_MODE_SET);
		rd_chk = 1'b1;
		issue(mk(PIN_READ, 1, 0, 3'h0, 15'h0000), CMD_READ);
		for (int n = 0; n < 100 && rd_cnt != 8'h08; n++) begin
			tick(1);
		end
		tick(12);
		check({rd_cnt, dq_oe_b, dqs_oe_b}, {8'h08, 2'b11});
		rd_chk = 1'b0;
		// leveling feedback follows the command clock level
		issue(mk(PIN_MODE, 1, 0, BA_MR1, 15'h0080), CMD_MODE_SET);
		u_ctl.lvl(1'b1);
		check({dq_oe_b, dq_o[0]}, 2'b01);
		u_ctl.lvl(1'b0);
		check({dq_oe_b, dq_o[0]}, 2'b00);
		issue(mk(PIN_MODE, 1, 0, BA_MR1, 15'h0000), CMD_MODE_SET);
		tick(4);
		check(dq_oe_b, 1'b1);
		// stalled sink: two words kept, the rest flagged as lost
		wr_ready = 1'b0;
		got.delete();
		issue(mk(PIN_WRITE, 1, 0, 3'h0, 15'h0000), CMD_WRITE);
		u_ctl.burst(8'h20, 8'h00);
		tick(6);
		check(wr_overflow, 1'b1);
		wr_ready = 1'b1;
		tick(6);
		check(got.size(), 2);
		check({got[0], got[1]}, 16'h2021);
		// device reset pin clears everything without a command edge
		u_ctl.cmd(mk(4'hf, 1, 1, 3'h0, 15'h0000));
		tick(12);
		check(term_dq, 1'b1);
		u_ctl.rst(1'b0);
		tick(4);
		check({term_dq, wr_overflow, dq_oe_b, dqs_oe_b}, 4'h3);
		u_ctl.rst(1'b1);
		tick(4);
		test_done;
	end
endmodule
